/* File: spo_pkg.sv */
// Constants and types for the sync pulse output control block
package spo_pkg;
  // Register byte addresses
  localparam logic [31:0] SPO_A_PDEV    = 32'h4401_0932;
  localparam logic [31:0] SPO_A_TDEP    = 32'h4401_0934;
  localparam logic [31:0] SPO_A_PDEP    = 32'h4401_0935;
  localparam logic [31:0] SPO_A_OWN     = 32'h4401_0980;
  localparam logic [31:0] SPO_A_ACT     = 32'h4401_0981;
  localparam logic [31:0] SPO_A_PLEN    = 32'h4401_0982;
  localparam logic [31:0] SPO_A_STAT    = 32'h4401_0984;
  localparam logic [31:0] SPO_A_PSTAT   = 32'h4401_098e;
  localparam logic [31:0] SPO_A_SSTAT   = 32'h4401_098f;
  localparam logic [31:0] SPO_A_START   = 32'h4401_0990;
  localparam logic [31:0] SPO_A_CYC     = 32'h4401_09a0;
  localparam logic [31:0] SPO_A_SCYC    = 32'h4401_09a4;
  // Reset values
  localparam logic [3:0]  SPO_TDEP_RST  = 4'h4;
  localparam logic [3:0]  SPO_PDEP_RST  = 4'hc;
  // Ownership and activation bit positions
  localparam int SPO_B_CAPTURE_UNIT_A_OWNER = 4;
  localparam int SPO_B_DBG    = 7;
  localparam int SPO_B_NEAR   = 6;
  localparam int SPO_B_PLAUS  = 5;
  localparam int SPO_B_EXT    = 4;
  localparam int SPO_B_AUTO   = 3;
  localparam int SPO_B_SEC    = 2;
  localparam int SPO_B_PRI    = 1;
  localparam int SPO_B_ACT    = 0;
  // Byte index that completes a start time write
  localparam logic [2:0]  SPO_START_LO_LAST = 3'h3;
  localparam logic [2:0]  SPO_START_HI_LAST = 3'h7;
  // Deviation bound offset and short window width
  localparam logic [15:0] SPO_DEV_OFS   = 16'h007f;
  localparam int          SPO_NEAR_SHORT_BIT = 31;
  // Pulse timing
  localparam int          SPO_CLK_NS    = 25;
  localparam int          SPO_LEN_STEP_NS = 10;
  localparam logic [19:0] SPO_CLK_STEP  = 20'(SPO_CLK_NS);
  localparam logic [3:0]  SPO_LEN_MUL   = 4'(SPO_LEN_STEP_NS);
  // Unit state
  typedef enum logic [3:0] {
    SPO_OFF   = 4'b0001,
    SPO_ARMED = 4'b0010,
    SPO_RUN   = 4'b0100,
    SPO_DONE  = 4'b1000
  } spo_unit_e;
endpackage

/* File: spo_ctrl.sv */
// Sync pulse output unit: configuration, status and pulse timing
module spo_ctrl (
  // Clock and reset
  input  wire logic               ref_clk,
  input  wire logic               rst,
  // Register access
  input  wire logic [31:0]        reg_addr,
  input  wire logic               reg_wr,
  input  wire logic               reg_rd,
  input  wire logic [7:0]         reg_wdata,
  input  wire logic               reg_from_host,
  output logic [7:0]              reg_rdata_q,
  // Time base and filter samples
  input  wire logic [63:0]        sys_time,
  input  wire logic [14:0]        speed_count_start,
  input  wire logic [15:0]        period_sample,
  input  wire logic               period_sample_vld,
  input  wire logic [31:0]        time_diff_sample,
  input  wire logic               time_diff_vld,
  input  wire logic [15:0]        pulse_duration,
  // Latch interrupts
  input  wire logic [1:0]         latch_irq_in,
  output logic [1:0]              latch_irq_master_q,
  output logic [1:0]              latch_irq_host_q,
  // Outputs
  output logic [31:0]             mean_time_difference_q,
  output logic                    primary_timing_pulse,
  output logic                    secondary_timing_pulse
);
  import spo_pkg::*;

  //////////////////////////////////////////////////////////////////
  // Helpers
  // Moving average step
  function automatic logic [31:0] f_avg(input logic [31:0] acc,
                                        input logic [31:0] smp,
                                        input logic [3:0] dep);
    logic signed [31:0] d;
    d = $signed(smp) - $signed(acc);
    return acc + 32'(d >>> dep);
  endfunction

  // Time reached when now minus target is not negative
  function automatic logic f_reached(input logic [63:0] now, input logic [63:0] t);
    logic [63:0] d;
    d = now - t;
    return ~d[63];
  endfunction

  // Byte of a word by index
  function automatic logic [7:0] f_byte(input logic [63:0] v, input logic [2:0] i);
    return v[{i, 3'h0} +: 8];
  endfunction

  //////////////////////////////////////////////////////////////////
  // State
  logic [3:0]  tdep_q, tdep_d, pdep_q, pdep_d;
  logic [1:0]  lown_q, lown_d;
  logic        pown_q, pown_d;
  logic [6:0]  act_q, act_d;
  logic [31:0] tacc_d, pacc_q, pacc_d;
  logic [15:0] pdev_q, pdev_d;
  logic [63:0] start_q, start_d, next_q, next_d, snext_q, snext_d;
  logic [31:0] cyc_q, cyc_d, scyc_q, scyc_d;
  logic        sarm_q, sarm_d, plaus_q, plaus_d;
  logic [1:0]  pend_q, pend_d, sync_q, sync_d;
  logic [19:0] el_q [2];
  logic [19:0] el_d [2];
  logic [7:0]  rdata_d;
  logic [1:0]  irqm_d, irqh_d;
  spo_unit_e   st_q, st_d;

  // Decode and helper terms
  logic        owner_ok, wr_ok, mst_wr;
  logic [31:0] ofs;
  logic [2:0]  bi;
  logic [1:0]  fire;
  logic [63:0] dstart;
  logic        out_win;
  logic [19:0] len_ns;
  logic signed [31:0] lim;

  assign primary_timing_pulse   = sync_q[0];
  assign secondary_timing_pulse = sync_q[1];

  //////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    tdep_d  = tdep_q;
    pdep_d  = pdep_q;
    lown_d  = lown_q;
    pown_d  = pown_q;
    act_d   = act_q;
    tacc_d  = mean_time_difference_q;
    pacc_d  = pacc_q;
    pdev_d  = pdev_q;
    start_d = start_q;
    next_d  = next_q;
    snext_d = snext_q;
    cyc_d   = cyc_q;
    scyc_d  = scyc_q;
    sarm_d  = sarm_q;
    plaus_d = plaus_q;
    pend_d  = pend_q;
    sync_d  = sync_q;
    el_d    = el_q;
    st_d    = st_q;
    rdata_d = 8'h00;
    fire    = 2'b00;
    ofs     = reg_addr - SPO_A_START;
    bi      = ofs[2:0];
    owner_ok = (reg_from_host == pown_q);
    wr_ok    = reg_wr && owner_ok;
    mst_wr   = reg_wr && !reg_from_host;
    irqm_d = latch_irq_in & ~lown_q;
    irqh_d = latch_irq_in & lown_q;
    dstart = start_q - sys_time;
    out_win = act_q[SPO_B_NEAR] ? (dstart[63:SPO_NEAR_SHORT_BIT] != '0) : dstart[63];
    // Widen before the product so long pulses do not wrap
    len_ns = 20'(pulse_duration) * 20'(SPO_LEN_MUL);
    lim = 32'($signed({1'b0, speed_count_start}) - $signed({1'b0, SPO_DEV_OFS}));

    if (time_diff_vld) begin
      tacc_d = f_avg(mean_time_difference_q, time_diff_sample, tdep_q);
    end
    if (period_sample_vld) begin
      pacc_d = f_avg(pacc_q, 32'($signed(period_sample)), pdep_q);
      if ($signed(pacc_d) > lim) begin
        pdev_d = lim[15:0];
      end else if ($signed(pacc_d) < -lim) begin
        pdev_d = 16'(-lim);
      end else begin
        pdev_d = pacc_d[15:0];
      end
    end

    // Register writes
    if (mst_wr && reg_addr == SPO_A_TDEP) begin
      tdep_d = reg_wdata[3:0];
      tacc_d = '0;
    end
    if (mst_wr && reg_addr == SPO_A_PDEP) begin
      pdep_d = reg_wdata[3:0];
      pacc_d = '0;
      pdev_d = '0;
    end
    if (mst_wr && reg_addr == SPO_A_OWN) begin
      lown_d = reg_wdata[SPO_B_CAPTURE_UNIT_A_OWNER +: 2];
      pown_d = reg_wdata[0];
    end
    if (wr_ok && reg_addr == SPO_A_ACT) begin
      act_d = reg_wdata[6:0];
      if (reg_wdata[SPO_B_DBG]) begin
        fire = reg_wdata[SPO_B_SEC:SPO_B_PRI];
      end
    end
    if (wr_ok && !act_q[SPO_B_ACT] && ofs < 32'd8) begin
      start_d[{bi, 3'h0} +: 8] = reg_wdata;
      if (bi == SPO_START_LO_LAST && act_q[SPO_B_EXT]) begin
        start_d[63:32] = sys_time[63:32] + 32'(start_d[31:0] < sys_time[31:0]);
      end
      if ((bi == SPO_START_HI_LAST || (bi == SPO_START_LO_LAST && act_q[SPO_B_EXT]))
          && act_q[SPO_B_AUTO]) begin
        act_d[SPO_B_ACT] = 1'b1;
      end
    end
    if (wr_ok && reg_addr >= SPO_A_CYC && reg_addr < SPO_A_SCYC) begin
      cyc_d[{reg_addr[1:0], 3'h0} +: 8] = reg_wdata;
    end
    if (wr_ok && reg_addr >= SPO_A_SCYC && reg_addr < SPO_A_SCYC + 32'd4) begin
      scyc_d[{reg_addr[1:0], 3'h0} +: 8] = reg_wdata;
    end

    // Unit sequencing
    unique case (st_q)
      SPO_OFF: begin
        if (act_q[SPO_B_ACT]) begin
          st_d    = SPO_ARMED;
          plaus_d = out_win;
          pend_d  = 2'b11;
          next_d  = start_q;
        end
      end
      SPO_ARMED: begin
        if (f_reached(sys_time, next_q) || (act_q[SPO_B_PLAUS] && plaus_q)) begin
          fire[0] = act_q[SPO_B_PRI];
          pend_d[0] = 1'b0;
          next_d  = sys_time + 64'(cyc_q);
          st_d    = (cyc_q == '0) ? SPO_DONE : SPO_RUN;
        end
      end
      SPO_RUN: begin
        if (f_reached(sys_time, next_q)) begin
          fire[0] = act_q[SPO_B_PRI];
          next_d  = next_q + 64'(cyc_q);
        end
      end
      SPO_DONE: begin
      end
    endcase
    if (st_q != SPO_OFF && st_d != SPO_ARMED && st_q != st_d && st_q == SPO_ARMED
        || (st_q == SPO_RUN && f_reached(sys_time, next_q))) begin
      snext_d = sys_time + 64'(scyc_q);
      sarm_d  = act_q[SPO_B_SEC];
    end
    if (sarm_q && f_reached(sys_time, snext_q)) begin
      fire[1]   = 1'b1;
      pend_d[1] = 1'b0;
      sarm_d    = 1'b0;
    end

    // Pulse shaping per output
    for (int i = 0; i < 2; i++) begin
      if (fire[i]) begin
        sync_d[i] = 1'b1;
        el_d[i]   = '0;
      end else if (sync_q[i] && pulse_duration != '0) begin
        el_d[i] = el_q[i] + SPO_CLK_STEP;
        if (el_d[i] >= len_ns) begin
          sync_d[i] = 1'b0;
        end
      end
    end
    if (reg_rd && reg_from_host && pulse_duration == '0) begin
      if (reg_addr == SPO_A_PSTAT) begin
        sync_d[0] = fire[0];
      end
      if (reg_addr == SPO_A_SSTAT) begin
        sync_d[1] = fire[1];
      end
    end

    if (!act_q[SPO_B_ACT]) begin
      st_d   = SPO_OFF;
      pend_d = 2'b00;
      sarm_d = 1'b0;
      if (st_q != SPO_OFF) begin
        sync_d = 2'b00;
      end
    end

    // Read data
    if (reg_rd) begin
      if (reg_addr == SPO_A_PDEV || reg_addr == SPO_A_PDEV + 32'd1) begin
        rdata_d = f_byte({48'h0, pdev_q}, {2'b00, reg_addr[0]});
      end else if (reg_addr == SPO_A_TDEP) begin
        rdata_d = {4'h0, tdep_q};
      end else if (reg_addr == SPO_A_PDEP) begin
        rdata_d = {4'h0, pdep_q};
      end else if (reg_addr == SPO_A_OWN) begin
        rdata_d = {2'b00, lown_q, 3'b000, pown_q};
      end else if (reg_addr == SPO_A_ACT) begin
        rdata_d = {1'b0, act_q};
      end else if (reg_addr == SPO_A_PLEN || reg_addr == SPO_A_PLEN + 32'd1) begin
        rdata_d = f_byte({48'h0, pulse_duration}, {2'b00, reg_addr[0]});
      end else if (reg_addr == SPO_A_STAT) begin
        rdata_d = {5'h00, plaus_q & act_q[SPO_B_ACT], pend_q[1], pend_q[0]};
      end else if (reg_addr == SPO_A_PSTAT) begin
        rdata_d = {7'h00, sync_q[0] & (pulse_duration == '0)};
      end else if (reg_addr == SPO_A_SSTAT) begin
        rdata_d = {7'h00, sync_q[1] & (pulse_duration == '0)};
      end else if (ofs < 32'd8) begin
        rdata_d = f_byte(act_q[SPO_B_ACT] ? next_q : start_q, bi);
      end else if (reg_addr >= SPO_A_CYC && reg_addr < SPO_A_SCYC) begin
        rdata_d = f_byte({32'h0, cyc_q}, {1'b0, reg_addr[1:0]});
      end else if (reg_addr >= SPO_A_SCYC && reg_addr < SPO_A_SCYC + 32'd4) begin
        rdata_d = f_byte({32'h0, scyc_q}, {1'b0, reg_addr[1:0]});
      end
    end
  end

  //////////////////////////////////////////////////////////////////
  // Registers
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      tdep_q <= SPO_TDEP_RST;
      pdep_q <= SPO_PDEP_RST;
      lown_q <= '0;
      pown_q <= 1'b0;
      act_q  <= '0;
      mean_time_difference_q <= '0;
      pacc_q <= '0;
      pdev_q <= '0;
      start_q <= '0;
      next_q <= '0;
      snext_q <= '0;
      cyc_q  <= '0;
      scyc_q <= '0;
      sarm_q <= 1'b0;
      plaus_q <= 1'b0;
      pend_q <= '0;
      sync_q <= '0;
      el_q[0] <= '0;
      el_q[1] <= '0;
      st_q   <= SPO_OFF;
      reg_rdata_q <= '0;
      latch_irq_master_q <= '0;
      latch_irq_host_q <= '0;
    end else begin
      tdep_q <= tdep_d;
      pdep_q <= pdep_d;
      lown_q <= lown_d;
      pown_q <= pown_d;
      act_q  <= act_d;
      mean_time_difference_q <= tacc_d;
      pacc_q <= pacc_d;
      pdev_q <= pdev_d;
      start_q <= start_d;
      next_q <= next_d;
      snext_q <= snext_d;
      cyc_q  <= cyc_d;
      scyc_q <= scyc_d;
      sarm_q <= sarm_d;
      plaus_q <= plaus_d;
      pend_q <= pend_d;
      sync_q <= sync_d;
      el_q   <= el_d;
      st_q   <= st_d;
      reg_rdata_q <= rdata_d;
      latch_irq_master_q <= irqm_d;
      latch_irq_host_q <= irqh_d;
    end
  end
endmodule

/* File: spo_ctrl_asserts.sv */
// Port checks for the sync pulse output control block
module spo_ctrl_asserts
  import spo_pkg::*;
(
  // Clock and reset
  input wire logic        ref_clk,
  input wire logic        rst,
  // Register access
  input wire logic [31:0] reg_addr,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [7:0]  reg_wdata,
  input wire logic        reg_from_host,
  input wire logic [7:0]  reg_rdata_q,
  // Pulses and latch routing
  input wire logic [15:0] pulse_duration,
  input wire logic [1:0]  latch_irq_in,
  input wire logic [1:0]  latch_irq_master_q,
  input wire logic [1:0]  latch_irq_host_q,
  input wire logic        primary_timing_pulse,
  input wire logic        secondary_timing_pulse
);
  logic [2:0] own_q;
  logic [2:0] own_d;
  // Shadow of the ownership bits
  always_comb begin
    own_d = own_q;
    if (reg_wr && !reg_from_host && reg_addr == SPO_A_OWN) begin
      own_d = {reg_wdata[5:4], reg_wdata[0]};
    end
  end
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      own_q <= 3'h0;
    end else begin
      own_q <= own_d;
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////////////
  // Owner debug write and host acknowledge read
  sequence s_dbg;
    reg_wr && reg_addr == SPO_A_ACT && reg_wdata[SPO_B_DBG] && reg_from_host == own_q[0];
  endsequence
  sequence s_ack;
    reg_rd && reg_from_host && reg_addr == SPO_A_PSTAT && pulse_duration == 16'h0000;
  endsequence
  dbg_primary_a:
    assert property (s_dbg ##0 reg_wdata[SPO_B_PRI] |=> primary_timing_pulse)
    else $error("debug pulse missing on primary output");
  dbg_secondary_a:
    assert property (s_dbg ##0 reg_wdata[SPO_B_SEC] |=> secondary_timing_pulse)
    else $error("debug pulse missing on secondary output");
  dbg_read_a:
    assert property ($past(reg_rd && reg_addr == SPO_A_ACT) |-> !reg_rdata_q[SPO_B_DBG])
    else $error("debug bit read back as one");
  latch_host_a:
    assert property (!$past(rst) |-> latch_irq_host_q == $past(latch_irq_in & own_q[2:1]))
    else $error("latch request routed wrongly to host");
  latch_master_a:
    assert property (!$past(rst) |-> latch_irq_master_q == $past(latch_irq_in & ~own_q[2:1]))
    else $error("latch request routed wrongly to master");
  pulse_len_a:
    assert property ($rose(primary_timing_pulse) && pulse_duration == 16'h0003
      |=> primary_timing_pulse ##1 !primary_timing_pulse)
    else $error("primary pulse length wrong");
  ack_hold_a:
    assert property (primary_timing_pulse && pulse_duration == 16'h0000 && !reg_wr
      && !$past(reg_rd) && !reg_rd |=> primary_timing_pulse)
    else $error("primary output dropped without acknowledge");
  ack_clear_a:
    assert property (s_ack |-> ##[1:2] !primary_timing_pulse)
    else $error("primary output not cleared by host read");
  stat_resv_a:
    assert property ($past(reg_rd && reg_addr == SPO_A_PSTAT) |-> reg_rdata_q[7:1] == 7'h00)
    else $error("primary status upper bits not zero");
endmodule
bind spo_ctrl spo_ctrl_asserts i_chk (
  .ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_wdata(reg_wdata), .reg_from_host(reg_from_host), .reg_rdata_q(reg_rdata_q),
  .pulse_duration(pulse_duration), .latch_irq_in(latch_irq_in),
  .latch_irq_master_q(latch_irq_master_q), .latch_irq_host_q(latch_irq_host_q),
  .primary_timing_pulse(primary_timing_pulse), .secondary_timing_pulse(secondary_timing_pulse)
);

/* File: spo_bus_model.sv */
// Master and host access model with the local time base
module spo_bus_model (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst,
  // Register access
  output logic [31:0]      reg_addr,
  output logic             reg_wr,
  output logic             reg_rd,
  output logic [7:0]       reg_wdata,
  output logic             reg_from_host,
  input  wire logic [7:0]  reg_rdata_q,
  // Local system time in ns
  output logic [63:0]      sys_time
);
  timeunit 1ns;
  timeprecision 100ps;
  // Idle bus at time zero
  initial begin
    reg_addr      = 32'h0;
    reg_wr        = 1'b0;
    reg_rd        = 1'b0;
    reg_wdata     = 8'h00;
    reg_from_host = 1'b0;
  end
  // Time base advancing one clock period
  always @(negedge ref_clk or posedge rst) begin
    if (rst) sys_time <= 64'h0;
    else sys_time <= sys_time + 64'h19;
  end
  task automatic wr(input logic [31:0] a, input logic [7:0] d, input logic h);
    @(negedge ref_clk);
    reg_addr      = a;
    reg_wdata     = d;
    reg_from_host = h;
    reg_wr        = 1'b1;
    @(negedge ref_clk);
    reg_wr    = 1'b0;
    reg_addr  = ~a;
    reg_wdata = ~d;
  endtask
  // One byte read, data taken the cycle after
  task automatic rd(input logic [31:0] a, input logic h, output logic [7:0] d);
    @(negedge ref_clk);
    reg_addr      = a;
    reg_from_host = h;
    reg_rd        = 1'b1;
    @(negedge ref_clk);
    reg_rd   = 1'b0;
    reg_addr = ~a;
    d        = reg_rdata_q;
  endtask
endmodule

/* File: tb.sv */
// Self-checking bench for the sync pulse output control block
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  import spo_pkg::*;
  logic        ref_clk, rst, reg_wr, reg_rd, reg_from_host, pri, sec;
  logic        period_sample_vld, time_diff_vld;
  logic [31:0] reg_addr, time_diff_sample, rs, mtd;
  logic [7:0]  reg_wdata, reg_rdata_q, rv;
  logic [63:0] sys_time, t0;
  logic [15:0] period_sample, pulse_duration;
  logic [1:0]  latch_irq_in;
  int          n_fail, check_count, n_hi;
  int          mdl[logic [31:0]];
  spo_ctrl i_dut (
    .ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_from_host(reg_from_host), .reg_rdata_q(reg_rdata_q),
    .sys_time(sys_time), .speed_count_start(15'h1000), .period_sample(period_sample),
    .period_sample_vld(period_sample_vld), .time_diff_sample(time_diff_sample),
    .time_diff_vld(time_diff_vld), .pulse_duration(pulse_duration),
    .latch_irq_in(latch_irq_in), .latch_irq_master_q(), .latch_irq_host_q(),
    .mean_time_difference_q(mtd), .primary_timing_pulse(pri), .secondary_timing_pulse(sec));
  spo_bus_model i_bus (
    .ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_from_host(reg_from_host), .reg_rdata_q(reg_rdata_q),
    .sys_time(sys_time));
  ////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction
  // Random filter samples and latch requests
  always @(negedge ref_clk) begin
    rs                <= xs(rs);
    period_sample     <= rs[15:0];
    period_sample_vld <= rs[16];
    time_diff_sample  <= {16'h0, rs[31:16]};
    time_diff_vld     <= rs[17];
    latch_irq_in      <= rst ? 2'h0 : rs[19:18];
  end
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic rdc(input string nm, input logic [31:0] a, input logic h, input logic [7:0] e);
    i_bus.rd(a, h, rv);
    chk(nm, rv, e);
  endtask
  // Write and update the register model
  task automatic bw(input logic [31:0] a, input logic [7:0] d, input logic h);
    i_bus.wr(a, d, h);
    if (a == SPO_A_ACT && h == mdl[SPO_A_OWN][0]) mdl[a] = d & 8'h7f;
    if ((a == SPO_A_OWN || a == SPO_A_TDEP || a == SPO_A_PDEP) && !h) mdl[a] = d;
  endtask
  task automatic cmp_model;
    foreach (mdl[a]) rdc("model_reg", a, 1'b0, 8'(mdl[a]));
  endtask
  task automatic wst(input logic [63:0] v);
    for (int i = 0; i < 8; i++) bw(SPO_A_START + 32'(i), v[8*i +: 8], 1'b1);
  endtask
  task automatic wait_hi(input logic w, input int lim);
    for (int k = 0; k < lim && (w ? sec : pri) !== 1'b1; k++) @(negedge ref_clk);
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    repeat (4000) @(posedge ref_clk);
    n_fail++;
    report_and_stop();
  end
  ////////////////////////////////////////////////////////////////////////
  initial begin
    rst = 1'b1;
    rs = 32'h51;
    pulse_duration = 16'h0003;
    latch_irq_in = 2'h0;
    {period_sample, period_sample_vld, time_diff_sample, time_diff_vld} = '0;
    n_fail = 0;
    check_count = 0;
    mdl = '{SPO_A_OWN: 0, SPO_A_ACT: 0, SPO_A_TDEP: 4, SPO_A_PDEP: 12};
    repeat (8) @(posedge ref_clk);
    @(negedge ref_clk) rst = 1'b0;
    cmp_model();
    rdc("act_stat", SPO_A_STAT, 1'b0, 8'h00);
    rdc("unmapped", 32'h4401_0a00, 1'b0, 8'h00);
    // Depths, ownership to host, refused writes
    bw(SPO_A_TDEP, 8'h07, 1'b0);
    chk("mean_clr", mtd, 64'h0);
    bw(SPO_A_PDEP, 8'h03, 1'b0);
    bw(SPO_A_OWN, 8'h31, 1'b0);
    bw(SPO_A_OWN, 8'h00, 1'b1);
    bw(SPO_A_ACT, 8'h06, 1'b0);
    cmp_model();
    bw(SPO_A_ACT, 8'h86, 1'b1);
    @(negedge ref_clk);
    chk("dbg_pri", pri, 1'b1);
    chk("dbg_sec", sec, 1'b1);
    cmp_model();
    // Single shot run with secondary delay
    t0 = sys_time + 64'h1388;
    bw(SPO_A_SCYC, 8'h64, 1'b1);
    wst(t0);
    bw(SPO_A_ACT, 8'h07, 1'b1);
    rdc("pending", SPO_A_STAT, 1'b0, 8'h03);
    wait_hi(1'b0, 400);
    chk("pri_time", sys_time >= t0 && sys_time < t0 + 64'h64, 1'b1);
    wait_hi(1'b1, 40);
    chk("sec_time", sys_time >= t0 + 64'h64 && sys_time < t0 + 64'hc8, 1'b1);
    n_hi = 0;
    repeat (300) @(negedge ref_clk) n_hi += int'(pri);
    chk("one_shot", 64'(n_hi), 64'h0);
    rdc("done", SPO_A_STAT, 1'b0, 8'h00);
    bw(SPO_A_ACT, 8'h06, 1'b1);
    rdc("stopped", SPO_A_STAT, 1'b0, 8'h00);
    // Acknowledge mode on a debug pulse
    pulse_duration = 16'h0000;
    bw(SPO_A_ACT, 8'h82, 1'b1);
    repeat (4) @(negedge ref_clk);
    rdc("ack_m", SPO_A_PSTAT, 1'b0, 8'h01);
    chk("ack_hold", pri, 1'b1);
    rdc("ack_h", SPO_A_PSTAT, 1'b1, 8'h01);
    repeat (2) @(negedge ref_clk);
    chk("ack_clr", pri, 1'b0);
    // Auto activation, start far beyond the short window
    pulse_duration = 16'h0003;
    bw(SPO_A_ACT, 8'h6e, 1'b1);
    wst(sys_time + 64'h1_0000_0000);
    mdl[SPO_A_ACT] |= 1;
    wait_hi(1'b0, 6);
    chk("immediate", pri, 1'b1);
    repeat (20) @(negedge ref_clk);
    cmp_model();
    rdc("plaus", SPO_A_STAT, 1'b0, 8'h04);
    report_and_stop();
  end
endmodule
